// ---- tmac_pkg.sv ----
package tmac_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned TMAC_CLK_PERIOD_PS = 5000;
    // Settle time for sensor supply before sampling, in microseconds
    localparam int unsigned TMAC_SETTLE_US = 200000;
    localparam int unsigned TMAC_SETTLE_CYC = (TMAC_SETTLE_US * 1000) / (TMAC_CLK_PERIOD_PS / 1000);
    // Half period of tone and blink toggling, in microseconds
    localparam int unsigned TMAC_TOGGLE_US = 100000;
    localparam int unsigned TMAC_TOGGLE_CYC = (TMAC_TOGGLE_US * 1000) / (TMAC_CLK_PERIOD_PS / 1000);
    // Debounce stable time, in microseconds
    localparam int unsigned TMAC_DEBOUNCE_US = 10000;
    localparam int unsigned TMAC_DEBOUNCE_CYC = (TMAC_DEBOUNCE_US * 1000) / (TMAC_CLK_PERIOD_PS / 1000);
    // Cycles for the input synchronisers to fill after reset or restart
    localparam int unsigned TMAC_SYNC_CYC = 2;
    localparam int unsigned TMAC_CNT_W = 27;
    // ----------------------------------------
    // States
    // ----------------------------------------
    typedef enum logic [4:0] {
        TMAC_ST_START  = 5'b0_0001,
        TMAC_ST_SETTLE = 5'b0_0010,
        TMAC_ST_WATCH  = 5'b0_0100,
        TMAC_ST_BLINK  = 5'b0_1000,
        TMAC_ST_DONE   = 5'b1_0000
    } tmac_state_t;
endpackage : tmac_pkg

// ---- tmac_debounce.sv ----
`timescale 1ns/1ps
module tmac_debounce
    import tmac_pkg::*;
#(
    parameter int unsigned STABLE_CYC = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic raw_i,
    output logic level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic [TMAC_CNT_W-1:0] cnt;
    } tmac_deb_t;
    tmac_deb_t st_q;
    tmac_deb_t st_d;
    // ----------------------------------------
    // Synchroniser and debounce
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.s1 = raw_i;
        st_d.s2 = st_q.s1;
        if (st_q.s2 == st_q.lvl) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == TMAC_CNT_W'(STABLE_CYC - 1)) begin
            st_d.cnt = '0;
            st_d.lvl = st_q.s2;
        end else begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign level_o = st_q.lvl;
endmodule : tmac_debounce

// ---- tmac_ctrl.sv ----
`timescale 1ns/1ps
module tmac_ctrl
    import tmac_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = TMAC_SETTLE_CYC,
    parameter int unsigned TOGGLE_CYC = TMAC_TOGGLE_CYC,
    parameter int unsigned DEBOUNCE_CYC = TMAC_DEBOUNCE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic restart_switch_i,
    input wire logic mode_jumper_i,
    input wire logic impact_i,
    input wire logic mute_button_i,
    output logic buzzer_o,
    output logic indicator_o,
    output logic sensor_power_o,
    output logic alert_active_o
);
    typedef struct packed {
        tmac_state_t state;
        logic jmp_s1;
        logic jmp_s2;
        logic imp_s1;
        logic imp_s2;
        logic rst_s1;
        logic rst_s2;
        logic rst_prev;
        logic [TMAC_CNT_W-1:0] wait_cnt;
        logic [TMAC_CNT_W-1:0] tog_cnt;
        logic tone;
        logic blink;
        logic power;
        logic active;
    } tmac_ctrl_t;
    tmac_ctrl_t st_q;
    tmac_ctrl_t st_d;
    logic mute_lvl;
    logic tick;
    logic restart;
    logic sync_ready;
    // ----------------------------------------
    // Mute button debounce
    // ----------------------------------------
    // Button debounce
    tmac_debounce #(
        .STABLE_CYC(DEBOUNCE_CYC)
    ) u_mute_deb (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .raw_i(mute_button_i),
        .level_o(mute_lvl)
    );
    assign tick = (st_q.tog_cnt == TMAC_CNT_W'(TOGGLE_CYC - 1));
    assign restart = st_q.rst_s2 && !st_q.rst_prev;
    // Synchronisers are held clear in reset, so the jumper is valid only after they fill
    assign sync_ready = (st_q.wait_cnt == TMAC_CNT_W'(TMAC_SYNC_CYC));
    // ----------------------------------------
    // Sequence control
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.jmp_s1 = mode_jumper_i;
        st_d.jmp_s2 = st_q.jmp_s1;
        st_d.imp_s1 = impact_i;
        st_d.imp_s2 = st_q.imp_s1;
        st_d.rst_s1 = restart_switch_i;
        st_d.rst_s2 = st_q.rst_s1;
        st_d.rst_prev = st_q.rst_s2;
        st_d.tog_cnt = tick ? '0 : st_q.tog_cnt + 1'b1;
        case (st_q.state)
            TMAC_ST_START: begin
                st_d.wait_cnt = '0;
                if (!sync_ready) begin
                    st_d.wait_cnt = st_q.wait_cnt + 1'b1;
                end else if (st_q.jmp_s2) begin
                    st_d.tone = 1'b1;
                    st_d.power = 1'b1;
                    st_d.state = TMAC_ST_SETTLE;
                end else begin
                    st_d.blink = 1'b1;
                    st_d.state = TMAC_ST_BLINK;
                end
            end
            TMAC_ST_SETTLE: begin
                if (tick) begin
                    st_d.tone = !st_q.tone;
                end
                st_d.wait_cnt = st_q.wait_cnt + 1'b1;
                if (st_q.wait_cnt == TMAC_CNT_W'(SETTLE_CYC - 1)) begin
                    st_d.state = TMAC_ST_WATCH;
                end
            end
            TMAC_ST_WATCH: begin
                if (st_q.imp_s2) begin
                    st_d.tone = 1'b0;
                    st_d.power = 1'b0;
                    st_d.state = TMAC_ST_DONE;
                end else if (tick) begin
                    st_d.tone = !st_q.tone;
                end
            end
            TMAC_ST_BLINK: begin
                st_d.power = 1'b0;
                if (mute_lvl) begin
                    st_d.blink = 1'b0;
                    st_d.state = TMAC_ST_DONE;
                end else if (tick) begin
                    st_d.blink = !st_q.blink;
                end
            end
            TMAC_ST_DONE: begin
                st_d.tone = 1'b0;
                st_d.blink = 1'b0;
                st_d.power = 1'b0;
            end
            default: begin
                st_d.state = TMAC_ST_START;
            end
        endcase
        if (restart) begin
            st_d.state = TMAC_ST_START;
            st_d.tone = 1'b0;
            st_d.blink = 1'b0;
            st_d.power = 1'b0;
            st_d.tog_cnt = '0;
            st_d.wait_cnt = '0;
        end
        // Alert status flag follows the next state
        st_d.active = (st_d.state != TMAC_ST_DONE);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '{state: TMAC_ST_START, active: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end
    assign buzzer_o = st_q.tone;
    assign indicator_o = st_q.blink;
    assign sensor_power_o = st_q.power;
    assign alert_active_o = st_q.active;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_impact_seen;
        (st_q.state == TMAC_ST_WATCH) && st_q.imp_s2 && !restart;
    endsequence
    sequence s_quiet_after;
        !buzzer_o && !sensor_power_o && (st_q.state == TMAC_ST_DONE);
    endsequence
    a_impact_mutes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_impact_seen |=> s_quiet_after)
        else $error("Impact did not mute tone");
    a_sound_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_START) && sync_ready && st_q.jmp_s2 && !restart
        |=> buzzer_o && sensor_power_o)
        else $error("Sound mode did not start tone");
    a_watch_power: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_WATCH) |-> sensor_power_o)
        else $error("Sensor unpowered while watching");
    a_settle_nomute: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_SETTLE) && !restart |=> st_q.state != TMAC_ST_DONE)
        else $error("Muted before sampling");
    a_silence_blink: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_BLINK) |-> !buzzer_o)
        else $error("Buzzer active in silence mode");
    a_silence_nopow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_BLINK) && st_q.imp_s2 && !mute_lvl && !restart |=> (st_q.state == TMAC_ST_BLINK)
        && !sensor_power_o)
        else $error("Silence mode used comparator or power");
    a_mute_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_BLINK) && mute_lvl && !restart |=> !indicator_o ##1 !indicator_o)
        else $error("Mute button did not stop blink");
    a_restart_seq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        restart |=> (st_q.state == TMAC_ST_START) && !buzzer_o && !indicator_o)
        else $error("Restart did not return to start");
    a_jumper_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_q.jmp_s2 == $past(mode_jumper_i, 2) || $past(!rst_n_i, 2))
        else $error("Jumper synchroniser depth wrong");

    // ----------------------------------------
    // Start-up, synchroniser, settle, watch and end checks
    // ----------------------------------------
    a_start_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_START) && !sync_ready && !restart |=> (st_q.state == TMAC_ST_START)
        && !buzzer_o && !indicator_o)
        else $error("Mode decided before synchronisers filled");
    a_silence_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_START) && sync_ready && !st_q.jmp_s2 && !restart |=> indicator_o && !buzzer_o
        && !sensor_power_o)
        else $error("Silence mode did not start blink");
    a_settle_power: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_SETTLE) |-> sensor_power_o && !indicator_o)
        else $error("Sensor unpowered while settling");
    a_impact_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_q.imp_s2 == $past(impact_i, 2) || $past(!rst_n_i, 2))
        else $error("Comparator synchroniser depth wrong");
    a_done_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_DONE) |-> !buzzer_o && !indicator_o && !sensor_power_o && !alert_active_o)
        else $error("Outputs active after alert ended");
    a_watch_steady: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_q.state == TMAC_ST_WATCH) && !st_q.imp_s2 && !tick && !restart |=> $stable(buzzer_o))
        else $error("Tone changed between ticks");
endmodule : tmac_ctrl

// ---- tmac_partner.sv ----
`timescale 1ns/1ps
module tmac_partner (
    input wire logic clk_i,
    input wire logic sensor_power_i,
    input wire logic tap_i,
    input wire logic press_i,
    input wire logic bounce_i,
    output logic impact_o,
    output logic mute_button_o
);
    logic [2:0] chatter_q = 3'h0;
    // comparator high below reference
    // Unpowered sensor sits at 0 V, under the reference, so it reads high
    assign impact_o = ~sensor_power_i | tap_i;
    // Contact chatter for five cycles after a press change
    always @(posedge clk_i) begin
        chatter_q <= bounce_i ? 3'h5 : ((chatter_q == 3'h0) ? 3'h0 : chatter_q - 3'h1);
    end
    assign mute_button_o = (chatter_q != 3'h0) ? chatter_q[0] : press_i;
endmodule : tmac_partner

// ---- test_tap_mute_alert_controller.sv ----
`timescale 1ns/1ps
module test_tap_mute_alert_controller;
    import tmac_pkg::*;
    localparam int unsigned SETTLE = 20;
    localparam int unsigned TOGGLE = 4;
    localparam int unsigned DEB = 4;
    logic clk_i = 1'b0, rst_n_i = 1'b0, restart_switch_i = 1'b0, mode_jumper_i = 1'b1;
    logic tap = 1'b0, press = 1'b0, bounce = 1'b0;
    logic impact_i, mute_button_i, buzzer_o, indicator_o, sensor_power_o, alert_active_o;
    logic [7:0] nb, ni;
    int n_fail = 0, total_checks = 0;
    integer seed = 32'h0000_cf2e;
    always #2.5 clk_i = ~clk_i;
    tmac_ctrl #(.SETTLE_CYC(SETTLE), .TOGGLE_CYC(TOGGLE), .DEBOUNCE_CYC(DEB)) dut (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .restart_switch_i(restart_switch_i), .mode_jumper_i(mode_jumper_i),
        .impact_i(impact_i), .mute_button_i(mute_button_i), .buzzer_o(buzzer_o),
        .indicator_o(indicator_o), .sensor_power_o(sensor_power_o), .alert_active_o(alert_active_o));
    tmac_partner u_partner (.clk_i(clk_i), .sensor_power_i(sensor_power_o), .tap_i(tap),
        .press_i(press), .bounce_i(bounce), .impact_o(impact_i), .mute_button_o(mute_button_i));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task test_done;
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    function automatic logic [7:0] exp_out(input logic sound, input logic ended);
        return {6'h00, sound & ~ended, ~ended};
    endfunction : exp_out
    task count_toggles;
        logic pb, pi;
        nb = 8'h00;
        ni = 8'h00;
        pb = buzzer_o;
        pi = indicator_o;
        repeat (3 * TOGGLE) begin
            cyc(1);
            if (buzzer_o !== pb) nb++;
            if (indicator_o !== pi) ni++;
            pb = buzzer_o;
            pi = indicator_o;
        end
    endtask : count_toggles
    task push(input logic v);
        @(posedge clk_i);
        press <= v;
        bounce <= 1'b1;
        @(posedge clk_i);
        bounce <= 1'b0;
        #1;
    endtask : push
    // ----------------------------------------
    // One alert sequence
    // ----------------------------------------
    task run_seq(input logic sound);
        int k;
        @(posedge clk_i);
        mode_jumper_i <= sound;
        cyc(3);
        @(posedge clk_i);
        restart_switch_i <= 1'b1;
        cyc(3);
        @(posedge clk_i);
        restart_switch_i <= 1'b0;
        tap <= 1'b1;
        cyc(3);
        tap <= ~sound;
        check({6'h00, sensor_power_o, alert_active_o}, exp_out(sound, 1'b0));
        count_toggles();
        check(nb, sound ? 8'h03 : 8'h00);
        check(ni, sound ? 8'h00 : 8'h03);
        if (sound) begin
            cyc(SETTLE);
            push(1'b1);
            cyc(DEB + 10);
            check({6'h00, sensor_power_o, alert_active_o}, exp_out(1'b1, 1'b0));
            push(1'b0);
            cyc(($random(seed) & 7) + 6);
            @(posedge clk_i);
            tap <= 1'b1;
            cyc(2);
            check({7'h00, alert_active_o}, 8'h01);
            cyc(1);
            check({5'h00, buzzer_o, sensor_power_o, alert_active_o}, 8'h00);
            tap <= 1'b0;
        end else begin
            check({6'h00, sensor_power_o, alert_active_o}, exp_out(1'b0, 1'b0));
            push(1'b1);
            k = 0;
            while (alert_active_o !== 1'b0 && k < 30) begin
                cyc(1);
                k++;
            end
            check({6'h00, indicator_o, alert_active_o}, 8'h00);
            push(1'b0);
        end
        count_toggles();
        check({nb[5:0] | ni[5:0], sensor_power_o, alert_active_o}, 8'h00);
    endtask : run_seq
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        cyc(3);
        check({6'h00, sensor_power_o, alert_active_o}, exp_out(1'b1, 1'b0));
        for (int i = 0; i < 8; i++) begin
            run_seq((i < 2) ? ~i[0] : (($random(seed) & 1) != 0));
        end
        test_done();
    end
    initial begin
        #(5 * 20000);
        n_fail++;
        test_done();
    end
endmodule : test_tap_mute_alert_controller
